/* File: zcb_defs.vh */
// Constants for the zero-compare branch unit
`ifndef ZCB_DEFS_VH
`define ZCB_DEFS_VH

// ----------------------------------------
// Instruction fields (bit 0 is the msb)
// ----------------------------------------
`define ZCB_OPC_REG 6'h27
`define ZCB_OPC_IMM 6'h2F
`define ZCB_OPC_PREFIX 6'h2C
`define ZCB_COND_EQ 4'h0
`define ZCB_COND_GE 4'h5
`define ZCB_COND_GT 4'h4
`define ZCB_SEQ_STEP 32'h0000_0004

// ----------------------------------------
// Latencies in cycles
// ----------------------------------------
`define ZCB_LAT_NOT_TAKEN 4'h1
`define ZCB_LAT_DELAY 4'h2
`define ZCB_LAT_NO_DELAY 4'h3
`define ZCB_LAT_MISP_FAST 4'h3
`define ZCB_LAT_MISP_AREA 4'h8

`endif

/* File: zcb_cond.v */
// Condition evaluator for the zero-compare branches
module zcb_cond
(
    // Operands
    input wire [31:0] src_val,
    input wire [3:0] cond_sel,
    // Result
    output reg cond_true,
    output reg cond_valid
);
`include "zcb_defs.vh"

    // ----------------------------------------
    // Signed compare against zero
    // ----------------------------------------
    always @*
    begin
        cond_true = 1'b0;
        cond_valid = 1'b1;
        case (cond_sel)
            `ZCB_COND_EQ: cond_true = (src_val == 32'h0000_0000); // RULE2
            `ZCB_COND_GE: cond_true = ~src_val[31]; // RULE3 RULE19
            `ZCB_COND_GT: cond_true = ~src_val[31] & (src_val != 32'h0000_0000); // RULE4 RULE19
            default: cond_valid = 1'b0;
        endcase
    end
endmodule // zcb_cond

/* File: zcb_branch_unit.v */
// Zero-compare branch decode and execute unit
// Functional notes
// RULE1: Decode opcode, delay, source, offset fields
// RULE2: Equal-immediate branch adds offset when zero
// RULE3: Greater-or-equal taken when source >= 0
// RULE4: Greater-than register branch needs source > 0
// RULE5: Register target is pc plus offset register
// RULE6: Immediate target is pc plus immediate
// RULE7: Not taken advances pc by four only
// RULE8: Delay flag marks delayed variants
// RULE9: Taken delayed branch lets slot complete
// RULE10: Taken undelayed branch discards the follower
// RULE11: Sign-extend 16-bit immediate by default
// RULE12: Preceding prefix supplies upper offset bits
// RULE13: Not taken completes in one cycle
// RULE14: Taken delayed completes in two cycles
// RULE15: Taken undelayed completes in three cycles
// RULE16: Correct prediction completes in one cycle
// RULE17: Misprediction costs three cycles, setting zero
// RULE18: Misprediction costs seven to nine, setting two
// RULE19: Signed compare selected by bits 7-10
module zcb_branch_unit
#(
    parameter AREA_OPTIMIZATION_SETTING = 0
)
(
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Issue from decode
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [31:0] instr_pc,
    input wire [31:0] compare_source_register,
    input wire [31:0] offset_register,
    // Prediction for immediate forms
    input wire pred_valid,
    input wire pred_taken,
    // Program counter update
    output reg pc_load,
    output reg [31:0] pc_next,
    // Pipeline control
    output reg busy,
    output reg done,
    output reg discard_follower,
    output reg delay_slot_run,
    output reg is_branch,
    output reg branch_taken,
    output reg mispredict
);
`include "zcb_defs.vh"

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    wire [5:0] opc = instr_word[31:26]; // RULE1
    wire delay_flag = instr_word[25]; // RULE1 RULE8
    wire [3:0] cond_sel = instr_word[24:21]; // RULE19
    wire [15:0] imm_field = instr_word[15:0]; // RULE1
    wire opc_reg = (opc == `ZCB_OPC_REG);
    wire opc_imm = (opc == `ZCB_OPC_IMM);
    wire opc_prefix = (opc == `ZCB_OPC_PREFIX);
    wire cond_true;
    wire cond_valid;

    zcb_cond u_cond
    (
        .src_val(compare_source_register),
        .cond_sel(cond_sel),
        .cond_true(cond_true),
        .cond_valid(cond_valid)
    );

    // Only beq-immediate of the equal forms lives here
    wire cond_ok = cond_valid & ~(opc_reg & (cond_sel == `ZCB_COND_EQ));
    wire is_br = instr_valid & cond_ok & (opc_reg | opc_imm);

    // ----------------------------------------
    // Prefix capture
    // ----------------------------------------
    reg prefix_valid_r;
    reg [15:0] prefix_hi_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            prefix_valid_r <= 1'b0;
            prefix_hi_r <= 16'h0000;
        end
        else if (instr_valid)
        begin
            // Prefix only counts for the instruction right after it
            prefix_valid_r <= opc_prefix; // RULE12
            if (opc_prefix)
                prefix_hi_r <= imm_field;
        end
    end

    function [31:0] imm_ext;
        input [15:0] lo;
        input pv;
        input [15:0] hi;
        begin
            if (pv)
                imm_ext = {hi, lo}; // RULE12
            else
                imm_ext = {{16{lo[15]}}, lo}; // RULE11
        end
    endfunction

    wire [31:0] offset = opc_imm ? imm_ext(imm_field, prefix_valid_r, prefix_hi_r) : offset_register;
    wire [31:0] target = instr_pc + offset; // RULE5 RULE6
    wire [31:0] seq_pc = instr_pc + `ZCB_SEQ_STEP; // RULE7
    wire predicted = opc_imm & pred_valid;
    wire mispred = predicted & (pred_taken != cond_true);
    wire [3:0] misp_lat = (AREA_OPTIMIZATION_SETTING == 2) ? `ZCB_LAT_MISP_AREA : `ZCB_LAT_MISP_FAST; // RULE17 RULE18

    reg [3:0] lat;
    always @*
    begin
        if (predicted & ~mispred)
            lat = `ZCB_LAT_NOT_TAKEN; // RULE16
        else if (mispred)
            lat = misp_lat;
        else if (~cond_true)
            lat = `ZCB_LAT_NOT_TAKEN; // RULE13
        else if (delay_flag)
            lat = `ZCB_LAT_DELAY; // RULE14
        else
            lat = `ZCB_LAT_NO_DELAY; // RULE15
    end

    // ----------------------------------------
    // Execute sequencer
    // ----------------------------------------
    reg [1:0] state_r;
    reg [3:0] cnt_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            pc_load <= 1'b0;
            pc_next <= 32'h0000_0000;
            busy <= 1'b0;
            done <= 1'b0;
            discard_follower <= 1'b0;
            delay_slot_run <= 1'b0;
            is_branch <= 1'b0;
            branch_taken <= 1'b0;
            mispredict <= 1'b0;
        end
        else
        begin
            pc_load <= 1'b0;
            done <= 1'b0;
            discard_follower <= 1'b0;
            delay_slot_run <= 1'b0;
            mispredict <= 1'b0;
            is_branch <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (is_br)
                    begin
                        is_branch <= 1'b1;
                        branch_taken <= cond_true;
                        mispredict <= mispred;
                        // Pc is the only state changed
                        pc_next <= cond_true ? target : seq_pc; // RULE2 RULE7
                        pc_load <= 1'b1;
                        delay_slot_run <= cond_true & delay_flag; // RULE9
                        discard_follower <= cond_true & ~delay_flag; // RULE10
                        if (lat == `ZCB_LAT_NOT_TAKEN)
                            done <= 1'b1; // RULE13 RULE16
                        else
                        begin
                            busy <= 1'b1;
                            cnt_r <= lat - 4'h1;
                            state_r <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT:
                begin
                    if (cnt_r == 4'h1)
                    begin
                        done <= 1'b1; // RULE14 RULE15 RULE17 RULE18
                        busy <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    cnt_r <= cnt_r - 4'h1;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // zcb_branch_unit

/* File: zcb_props.sv */
// Port checks for the zero-compare branch unit
`include "zcb_defs.vh"
module zcb_props #(parameter AREA_OPTIMIZATION_SETTING = 0) (
    // Clock, reset and issue
    input wire mclk,
    input wire rst,
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire [31:0] instr_pc,
    // Results
    input wire pc_load,
    input wire [31:0] pc_next,
    input wire busy,
    input wire done,
    input wire discard_follower,
    input wire delay_slot_run,
    input wire is_branch,
    input wire branch_taken,
    input wire mispredict
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire [5:0] op = instr_word[31:26];
    wire [3:0] cc = instr_word[24:21];
    wire imm = op == `ZCB_OPC_IMM;
    wire cok = cc == `ZCB_COND_GE || cc == `ZCB_COND_GT || (imm && cc == `ZCB_COND_EQ);
    wire ok = instr_valid && !busy && (imm || op == `ZCB_OPC_REG) && cok;
    a_issue_ack: assert property (ok |=> is_branch && pc_load)
        else $error("branch not acknowledged");
    a_refuse_busy: assert property (busy && instr_valid |=> !is_branch)
        else $error("issue accepted while busy");
    a_seq_pc: assert property (pc_load && !branch_taken |-> pc_next == $past(instr_pc) + `ZCB_SEQ_STEP)
        else $error("sequential pc wrong");
    a_nt_done: assert property (pc_load && !branch_taken && !mispredict |-> done)
        else $error("not taken not in one cycle");
    a_delay_two: assert property (delay_slot_run && !done && !mispredict |=> done)
        else $error("delayed branch not in two cycles");
    a_nodelay_three: assert property (discard_follower && !done && !mispredict |=> !done ##1 done)
        else $error("undelayed branch not in three cycles");
    a_misp_cost: assert property (mispredict && AREA_OPTIMIZATION_SETTING == 0 |=> !done ##1 done)
        else $error("mispredict cost wrong");
    a_delay_flag: assert property (is_branch && branch_taken && !done |->
        delay_slot_run == $past(instr_word[25]) && discard_follower == !$past(instr_word[25]))
        else $error("slot handling does not follow delay flag");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:8] done)
        else $error("busy without done");
    c_slot: cover property (delay_slot_run);
    c_discard: cover property (discard_follower);
    c_misp: cover property (mispredict);
endmodule // zcb_props
bind zcb_branch_unit zcb_props #(.AREA_OPTIMIZATION_SETTING(AREA_OPTIMIZATION_SETTING)) u_zcb_props
(
    .mclk(mclk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_pc(instr_pc),
    .pc_load(pc_load),
    .pc_next(pc_next),
    .busy(busy),
    .done(done),
    .discard_follower(discard_follower),
    .delay_slot_run(delay_slot_run),
    .is_branch(is_branch),
    .branch_taken(branch_taken),
    .mispredict(mispredict)
);

/* File: tb_top.sv */
// Random and corner stimulus for the branch unit
`include "zcb_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst = 1, instr_valid = 0, pred_valid = 0, pred_taken = 0;
    logic [31:0] instr_word = 0, instr_pc = 0, compare_source_register = 0, offset_register = 0;
    wire pc_load, busy, done, discard_follower, delay_slot_run, is_branch, branch_taken, mispredict;
    wire [31:0] pc_next;
    int errors = 0, total_checks = 0, cyc = 0;
    logic [31:0] seed = 32'h6df1_d4e1;
    zcb_branch_unit u_zcb_branch_unit
    (
        .mclk(mclk),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .instr_pc(instr_pc),
        .compare_source_register(compare_source_register),
        .offset_register(offset_register),
        .pred_valid(pred_valid),
        .pred_taken(pred_taken),
        .pc_load(pc_load),
        .pc_next(pc_next),
        .busy(busy),
        .done(done),
        .discard_follower(discard_follower),
        .delay_slot_run(delay_slot_run),
        .is_branch(is_branch),
        .branch_taken(branch_taken),
        .mispredict(mispredict)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g)
        begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Corner source values 0, -1, 1 mixed with random ones
    task automatic shot;
        logic [31:0] r, s, src, off, pc, tgt;
        logic [3:0] c;
        logic im, pf, d, pv, pt, tk, mp;
        int el, n;
        seed = lfsr(seed);
        r = seed;
        seed = lfsr(seed);
        s = seed;
        im = r[0];
        c = (r[2:1] == 0 && im) ? `ZCB_COND_EQ : r[1] ? `ZCB_COND_GE : `ZCB_COND_GT;
        src = r[4:3] == 0 ? 0 : r[4:3] == 1 ? 32'hffff_ffff : r[4:3] == 2 ? 1 : s;
        pf = im & r[5];
        d = r[6];
        pv = im & r[7];
        pt = r[8];
        pc = {r[31:12], 12'h0};
        tk = c == `ZCB_COND_EQ ? src == 0 : c == `ZCB_COND_GE ? !src[31] : !src[31] && src != 0;
        off = !im ? s : pf ? {r[31:16], s[15:0]} : {{16{s[15]}}, s[15:0]};
        tgt = tk ? pc + off : pc + `ZCB_SEQ_STEP;
        mp = pv && pt != tk;
        el = mp ? 3 : (!tk || pv) ? 1 : d ? 2 : 3;
        if (pf)
        begin
            @(posedge mclk);
            instr_valid <= 1;
            instr_word <= {`ZCB_OPC_PREFIX, 10'h0, r[31:16]};
        end
        @(posedge mclk);
        instr_valid <= 1;
        instr_word <= {im ? `ZCB_OPC_IMM : `ZCB_OPC_REG, d, c, r[13:9], s[15:0]};
        instr_pc <= pc;
        compare_source_register <= src;
        offset_register <= s;
        pred_valid <= pv;
        pred_taken <= pt;
        @(posedge mclk);
        instr_valid <= 0;
        #1;
        chk("is_branch", 1, {31'h0, is_branch});
        chk("pc_next", tgt, pc_next);
        chk("taken", {31'h0, tk}, {31'h0, branch_taken});
        chk("mispredict", {31'h0, mp}, {31'h0, mispredict});
        chk("slot", {30'h0, tk && d, tk && !d}, {30'h0, delay_slot_run, discard_follower});
        chk("pc_load", 1, {31'h0, pc_load});
        chk("busy", {31'h0, el > 1}, {31'h0, busy});
        n = 1;
        // A refused issue rides in the last busy cycle of long branches
        while (done !== 1'b1 && n < 12)
        begin
            @(posedge mclk);
            instr_valid <= (n == 1 && el > 2);
            #1;
            n++;
        end
        chk("latency", el, n);
        // The issue raised while busy must leave no trace
        if (el > 2)
            chk("refused", 0, {31'h0, is_branch});
    endtask
    // Register form has no equal-to-zero variant here
    task automatic ignored_shot;
        @(posedge mclk);
        instr_valid <= 1;
        instr_word <= {`ZCB_OPC_REG, 1'b0, `ZCB_COND_EQ, 5'h00, 16'h0000};
        @(posedge mclk);
        instr_valid <= 0;
        #1;
        chk("ignored", 0, {31'h0, is_branch});
        chk("ignored_load", 0, {31'h0, pc_load});
    endtask
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 0;
        repeat (300) shot();
        $display("random branch test done");
        ignored_shot();
        $display("ignored opcode test done");
        close_out();
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end
endmodule // tb_top
